/* rtl/saef_top.sv */
// Operation
// - slave access error sets its flag; flag holds until software clears it.
// - interrupt asserted while any flag whose error mask bit is one is set and error interrupt enable is one.
// - writing one to a flag bit clears only that flag.
// - writing zero to a flag bit leaves it unchanged.
// - bit 0 records flash errors, bit 7 boot ROM errors.
// - bits 1 to 3 record the three bridge slave errors.
// - bits 4 to 6 record SRAM CPU, DMA and debug port errors.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module saef_top
    import saef_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    input  wire logic [SAEF_ADDR_W-1:0] paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [SAEF_DATA_W-1:0] pwdata,
    input  wire logic [SAEF_STRB_W-1:0] pstrb,
    output var  logic [SAEF_DATA_W-1:0] prdata,
    output var  logic                   pready,
    output var  logic                   pslverr,
    input  wire logic                   flash_error,
    input  wire logic                   bridge_a_error,
    input  wire logic                   bridge_b_error,
    input  wire logic                   bridge_c_error,
    input  wire logic                   sram_cpu_port_error,
    input  wire logic                   sram_dma_port_error,
    input  wire logic                   sram_debug_port_error,
    input  wire logic                   boot_rom_error,
    output var  logic                   irq
);
    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    saef_reg_if regs ();

    saef_apb_slave u_apb (
        .clk     (clk),
        .arst_n  (arst_n),
        .paddr   (paddr),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .pwdata  (pwdata),
        .pstrb   (pstrb),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .regs    (regs)
    );

    logic sel_en_clr;
    logic sel_en_set;
    logic sel_flags;
    logic sel_mask;
    logic lane0;

    assign sel_en_clr = (regs.addr == SAEF_OFS_INT_ENABLE_CLEAR);
    assign sel_en_set = (regs.addr == SAEF_OFS_INT_ENABLE_SET);
    assign sel_flags  = (regs.addr == SAEF_OFS_ACCESS_ERR_FLAGS);
    assign sel_mask   = (regs.addr == SAEF_OFS_ERROR_MASK);
    assign regs.hit   = sel_en_clr | sel_en_set | sel_flags | sel_mask;
    // only the low byte lane holds fields; upper lanes are dropped
    assign lane0      = regs.strb[SAEF_FLAG_LANE];

    // ----------------------------------------------------------------
    // error event map
    // ----------------------------------------------------------------
    logic [SAEF_SLAVES-1:0] slave_error;
    logic [SAEF_SLAVES-1:0] access_error_flags;
    logic [SAEF_SLAVES-1:0] flag_clear;

    always_comb begin
        slave_error                      = '0;
        slave_error[SAEF_BIT_FLASH]      = flash_error;
        slave_error[SAEF_BIT_BOOT_ROM]   = boot_rom_error;
        slave_error[SAEF_BIT_BRIDGE_A]   = bridge_a_error;
        slave_error[SAEF_BIT_BRIDGE_B]   = bridge_b_error;
        slave_error[SAEF_BIT_BRIDGE_C]   = bridge_c_error;
        slave_error[SAEF_BIT_SRAM_CPU]   = sram_cpu_port_error;
        slave_error[SAEF_BIT_SRAM_DMA]   = sram_dma_port_error;
        slave_error[SAEF_BIT_SRAM_DEBUG] = sram_debug_port_error;
    end

    // per-bit clear: a zero bit in the written word has no effect
    assign flag_clear = (regs.wr && sel_flags && lane0) ? regs.wdata[SAEF_SLAVES-1:0] : '0;

    // ----------------------------------------------------------------
    // sticky flags
    // ----------------------------------------------------------------
    for (genvar i = 0; i < SAEF_SLAVES; i++) begin : g_flag
        saef_flag_bit u_flag (
            .clk     (clk),
            .arst_n  (arst_n),
            .set_evt (slave_error[i]),
            .clr_wr  (flag_clear[i]),
            .flag    (access_error_flags[i])
        );
    end

    // ----------------------------------------------------------------
    // interrupt enable and per-slave mask
    // ----------------------------------------------------------------
    logic                   err_enable;
    logic [SAEF_SLAVES-1:0] error_mask;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            err_enable <= SAEF_RST_ERR_ENABLE;
        end else if (regs.wr && lane0 && regs.wdata[SAEF_BIT_ERR_ENABLE]) begin
            if (sel_en_set) begin
                err_enable <= 1'b1;
            end else if (sel_en_clr) begin
                err_enable <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            error_mask <= SAEF_RST_MASK;
        end else if (regs.wr && sel_mask && lane0) begin
            error_mask <= regs.wdata[SAEF_SLAVES-1:0];
        end
    end

    // level output, falls once the last unmasked flag is cleared
    assign irq = err_enable & (|(access_error_flags & error_mask));

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb begin
        regs.rdata = SAEF_ZERO_WORD;
        if (sel_flags) begin
            regs.rdata[SAEF_SLAVES-1:0] = access_error_flags;
        end else if (sel_mask) begin
            regs.rdata[SAEF_SLAVES-1:0] = error_mask;
        end else if (sel_en_set || sel_en_clr) begin
            regs.rdata[SAEF_BIT_ERR_ENABLE] = err_enable;
        end
    end
endmodule

`default_nettype wire

/* common/saef_pkg.sv */
package saef_pkg;

    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int unsigned SAEF_DATA_W  = 32;
    localparam int unsigned SAEF_ADDR_W  = 12;
    localparam int unsigned SAEF_SLAVES  = 8;
    localparam int unsigned SAEF_STRB_W  = SAEF_DATA_W / 8;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [SAEF_ADDR_W-1:0] SAEF_OFS_INT_ENABLE_CLEAR = 12'h000;
    localparam logic [SAEF_ADDR_W-1:0] SAEF_OFS_INT_ENABLE_SET   = 12'h004;
    localparam logic [SAEF_ADDR_W-1:0] SAEF_OFS_ACCESS_ERR_FLAGS = 12'h010;
    localparam logic [SAEF_ADDR_W-1:0] SAEF_OFS_ERROR_MASK       = 12'h014;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int unsigned SAEF_BIT_ERR_ENABLE = 0;
    localparam int unsigned SAEF_BIT_FLASH      = 0;
    localparam int unsigned SAEF_BIT_BRIDGE_A   = 1;
    localparam int unsigned SAEF_BIT_BRIDGE_B   = 2;
    localparam int unsigned SAEF_BIT_BRIDGE_C   = 3;
    localparam int unsigned SAEF_BIT_SRAM_CPU   = 4;
    localparam int unsigned SAEF_BIT_SRAM_DMA   = 5;
    localparam int unsigned SAEF_BIT_SRAM_DEBUG = 6;
    localparam int unsigned SAEF_BIT_BOOT_ROM   = 7;
    localparam int unsigned SAEF_FLAG_LANE      = 0;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [SAEF_SLAVES-1:0] SAEF_RST_FLAGS      = 8'h00;
    localparam logic [SAEF_SLAVES-1:0] SAEF_RST_MASK       = 8'hFF;
    localparam logic                   SAEF_RST_ERR_ENABLE = 1'b0;
    localparam logic [SAEF_DATA_W-1:0] SAEF_ZERO_WORD      = 32'h0000_0000;

endpackage

/* common/saef_reg_if.sv */
`timescale 1ns/100ps
`default_nettype none

interface saef_reg_if;
    import saef_pkg::*;

    logic [SAEF_ADDR_W-1:0] addr;
    logic [SAEF_DATA_W-1:0] wdata;
    logic [SAEF_STRB_W-1:0] strb;
    logic                   wr;
    logic [SAEF_DATA_W-1:0] rdata;
    logic                   hit;

    modport bus  (output addr, output wdata, output strb, output wr, input rdata, input hit);
    modport core (input addr, input wdata, input strb, input wr, output rdata, output hit);
endinterface

`default_nettype wire

/* rtl/saef_flag_bit.sv */
`timescale 1ns/100ps
`default_nettype none

module saef_flag_bit
    import saef_pkg::*;
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic set_evt,
    input  wire logic clr_wr,
    output var  logic flag
);
    // an event in the clearing cycle survives the clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flag <= 1'b0;
        end else begin
            flag <= set_evt | (flag & ~clr_wr);
        end
    end
endmodule

`default_nettype wire

/* rtl/saef_apb_slave.sv */
`timescale 1ns/100ps
`default_nettype none

module saef_apb_slave
    import saef_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    input  wire logic [SAEF_ADDR_W-1:0] paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [SAEF_DATA_W-1:0] pwdata,
    input  wire logic [SAEF_STRB_W-1:0] pstrb,
    output var  logic [SAEF_DATA_W-1:0] prdata,
    output var  logic                   pready,
    output var  logic                   pslverr,
    saef_reg_if.bus                     regs
);
    // ----------------------------------------------------------------
    // decode state captured in the setup cycle
    // ----------------------------------------------------------------
    logic hit_q;
    logic setup;
    logic access;

    assign setup  = psel & ~penable;
    assign access = psel & penable;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hit_q <= 1'b0;
        end else if (setup) begin
            hit_q <= regs.hit;
        end
    end

    // read data sampled at the setup edge so prdata is a flop in access
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= SAEF_ZERO_WORD;
        end else if (setup) begin
            prdata <= (regs.hit && !pwrite) ? regs.rdata : SAEF_ZERO_WORD;
        end
    end

    // ----------------------------------------------------------------
    // zero wait state; unmapped access answers with an error
    // ----------------------------------------------------------------
    assign pready     = 1'b1;
    assign pslverr    = access & ~hit_q;
    assign regs.addr  = paddr;
    assign regs.wdata = pwdata;
    assign regs.strb  = pstrb;
    assign regs.wr    = access & pwrite & hit_q;
endmodule

`default_nettype wire

/* dv/saef_assertions.sv */
`timescale 1ns/100ps
`default_nettype none

module saef_assertions
    import saef_pkg::*;
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        irq,
    input wire logic        flash_error,
    input wire logic        bridge_a_error,
    input wire logic        bridge_b_error,
    input wire logic        bridge_c_error,
    input wire logic        sram_cpu_port_error,
    input wire logic        sram_dma_port_error,
    input wire logic        sram_debug_port_error,
    input wire logic        boot_rom_error
);
    logic [7:0] evt;
    assign evt = {boot_rom_error, sram_debug_port_error, sram_dma_port_error, sram_cpu_port_error,
                  bridge_c_error, bridge_b_error, bridge_a_error, flash_error};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ------------------------------------------------------------
    // flag register transfers
    // ------------------------------------------------------------
    sequence s_rd;
        psel && !penable && !pwrite && paddr == SAEF_OFS_ACCESS_ERR_FLAGS;
    endsequence
    sequence s_racc;
        psel && penable && !pwrite && paddr == SAEF_OFS_ACCESS_ERR_FLAGS;
    endsequence
    // an event in the write cycle wins over the clear, so exclude it
    sequence s_wacc;
        psel && penable && pwrite && pstrb[0] && evt == 8'h00 && paddr == SAEF_OFS_ACCESS_ERR_FLAGS;
    endsequence
    property p_set(e, int b);
        e ##1 s_rd |=> prdata[b];
    endproperty
    AST_FLASH_SET: assert property (p_set(flash_error, 0))
        else $error("flash error not flagged");
    AST_BOOT_SET: assert property (p_set(boot_rom_error, 7))
        else $error("boot rom error not flagged");
    AST_BRIDGE_SET: assert property ((evt[3:1] != 3'h0) ##1 s_rd |=> (prdata[3:1] & $past(evt[3:1], 2)) == $past(evt[3:1], 2))
        else $error("bridge error not flagged");
    AST_SRAM_SET: assert property ((evt[6:4] != 3'h0) ##1 s_rd |=> (prdata[6:4] & $past(evt[6:4], 2)) == $past(evt[6:4], 2))
        else $error("sram error not flagged");
    AST_STICKY: assert property (s_racc ##1 s_rd |=> (prdata[7:0] & $past(prdata[7:0], 2)) == $past(prdata[7:0], 2))
        else $error("flag dropped without clear");
    AST_W1C: assert property (s_wacc ##1 s_rd |=> (prdata[7:0] & $past(pwdata[7:0], 2)) == 8'h00)
        else $error("flag written one not cleared");
    AST_W0_KEEP: assert property (s_racc ##1 (psel && !penable && pwrite) ##1 s_wacc ##1 s_rd
        |=> (prdata[7:0] & $past(prdata[7:0], 4) & ~$past(pwdata[7:0], 2)) == ($past(prdata[7:0], 4) & ~$past(pwdata[7:0], 2)))
        else $error("flag written zero changed");
    AST_UPPER_ZERO: assert property (psel && penable |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    AST_IRQ_QUIET: assert property (s_racc ##0 (prdata[7:0] == 8'h00 && $past(evt) == 8'h00) |-> !irq)
        else $error("irq without flag");
endmodule

`default_nettype wire

/* dv/saef_err_src.sv */
`timescale 1ns/100ps
`default_nettype none

// slaves report errors one clock after the bench asks
module saef_err_src (
    input  wire logic       clk,
    input  wire logic [7:0] req,
    output var  logic [7:0] err
);
    always_ff @(posedge clk) begin
        err <= req;
    end
endmodule

`default_nettype wire

/* dv/saef_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module saef_top_tb;
    import saef_pkg::*;
    logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, irq, en, se;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, w;
    logic [3:0]  pstrb;
    logic [7:0]  req, err, exp_f, msk;
    int          errors, checks_done, seed, i;
    saef_top i_saef_top (.clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_error(err[0]), .bridge_a_error(err[1]), .bridge_b_error(err[2]),
        .bridge_c_error(err[3]), .sram_cpu_port_error(err[4]), .sram_dma_port_error(err[5]),
        .sram_debug_port_error(err[6]), .boot_rom_error(err[7]), .irq(irq));
    saef_err_src i_saef_err_src (.clk(clk), .req(req), .err(err));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // psel stays up between chained transfers so none is assigned twice
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic last);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            errors++;
            wrap_up();
        end
        rd = prdata;
        se = pslverr;
        penable <= 1'b0;
        if (last) begin
            psel <= 1'b0;
            @(posedge clk);
        end
    endtask
    function automatic logic [31:0] exp_irq();
        return {31'h0, en && (exp_f & msk) != 8'h00};
    endfunction
    task automatic hit(input logic [7:0] v);
        req <= v;
        @(posedge clk);
        req <= 8'h00;
        repeat (2) @(posedge clk);
        exp_f = exp_f | v;
    endtask
    task automatic rdf(input logic last);
        apb(1'b0, SAEF_OFS_ACCESS_ERR_FLAGS, 32'($random(seed)), last);
        chk("flags", {24'h0, exp_f}, rd);
    endtask
    initial begin
        seed = 32'hCC14ACB4;
        {arst_n, psel, penable, pwrite, paddr, pwdata, req, exp_f, en} = '0;
        pstrb = 4'hF;
        msk = 8'hFF;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, SAEF_OFS_ERROR_MASK, 32'h0, 1'b1);
        chk("mask", 32'hFF, rd);
        rdf(1'b1);
        for (i = 0; i < 8; i++) begin
            hit(8'h01 << i);
            rdf(1'b0);
            rdf(1'b1);
            chk("irq", 32'h0, {31'h0, irq});
        end
        apb(1'b1, SAEF_OFS_INT_ENABLE_SET, 32'h1, 1'b1);
        en = 1'b1;
        chk("irq", exp_irq(), {31'h0, irq});
        apb(1'b1, SAEF_OFS_ERROR_MASK, 32'h0, 1'b1);
        msk = 8'h00;
        chk("irq", exp_irq(), {31'h0, irq});
        apb(1'b1, SAEF_OFS_ERROR_MASK, 32'hFF, 1'b1);
        msk = 8'hFF;
        repeat (40) begin
            hit(8'($random(seed)));
            w = $random(seed);
            rdf(1'b0);
            apb(1'b1, SAEF_OFS_ACCESS_ERR_FLAGS, w, 1'b0);
            exp_f = exp_f & ~w[7:0];
            rdf(1'b1);
            chk("irq", exp_irq(), {31'h0, irq});
        end
        apb(1'b1, 12'hFFC, 32'hFFFFFFFF, 1'b1);
        chk("slverr", 32'h1, {31'h0, se});
        // error lands in the clearing write's access cycle: set must win
        req <= 8'h10;
        apb(1'b1, SAEF_OFS_ACCESS_ERR_FLAGS, 32'hFF, 1'b1);
        req <= 8'h00;
        exp_f = 8'h10;
        chk("slverr", 32'h0, {31'h0, se});
        // low byte lane off: the clear must be dropped
        pstrb <= 4'hE;
        apb(1'b1, SAEF_OFS_ACCESS_ERR_FLAGS, 32'hFF, 1'b1);
        pstrb <= 4'hF;
        rdf(1'b1);
        apb(1'b1, SAEF_OFS_ACCESS_ERR_FLAGS, 32'hFFFFFFFF, 1'b0);
        exp_f = 8'h00;
        rdf(1'b1);
        chk("irq", 32'h0, {31'h0, irq});
        hit(8'h80);
        chk("irq", exp_irq(), {31'h0, irq});
        apb(1'b0, SAEF_OFS_INT_ENABLE_SET, 32'h0, 1'b1);
        chk("enable", 32'h1, rd);
        apb(1'b1, SAEF_OFS_INT_ENABLE_CLEAR, 32'h1, 1'b1);
        en = 1'b0;
        chk("irq", exp_irq(), {31'h0, irq});
        // mid-run reset wipes the flags
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        exp_f = 8'h00;
        rdf(1'b1);
        chk("irq", 32'h0, {31'h0, irq});
        wrap_up();
    end
endmodule

bind saef_top saef_assertions i_saef_assertions (.clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .irq(irq),
    .flash_error(flash_error), .bridge_a_error(bridge_a_error), .bridge_b_error(bridge_b_error),
    .bridge_c_error(bridge_c_error), .sram_cpu_port_error(sram_cpu_port_error),
    .sram_dma_port_error(sram_dma_port_error), .sram_debug_port_error(sram_debug_port_error),
    .boot_rom_error(boot_rom_error));

`default_nettype wire
